// *** src/nvp_stage.sv ***
// Neutral overvoltage pick-up stage: register port, program cycle,
// source selection, hysteresis comparator, modes, forcing, interrupt.
// Assumes inputs synchronous to mclk and a one-cycle strobe master.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "nvp_map.svh"

module nvp_stage import nvp_pkg::*; #(
  parameter int unsigned EVAL_CYCLES = `NVP_EVAL_CYCLES, // Program cycle in clocks
  parameter int unsigned NUM_GROUPS = `NVP_NUM_GROUPS // Setting groups, at most 8
) (
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Async reset
  input wire logic [7:0] addr, // Register byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after strobe
  input wire logic signed [15:0] phase_a_voltage_re, // Phase A real part
  input wire logic signed [15:0] phase_a_voltage_im, // Phase A imaginary part
  input wire logic signed [15:0] phase_b_voltage_re, // Phase B real part
  input wire logic signed [15:0] phase_b_voltage_im, // Phase B imaginary part
  input wire logic signed [15:0] phase_c_voltage_re, // Phase C real part
  input wire logic signed [15:0] phase_c_voltage_im, // Phase C imaginary part
  input wire logic [15:0] aux_channel_three, // Aux three fundamental level
  input wire logic [15:0] aux_channel_four, // Aux four fundamental level
  input wire logic aux3_residual_mode, // Aux three set for residual
  input wire logic aux4_residual_mode, // Aux four set for residual
  input wire logic block_in, // Blocking matrix input
  output logic start_out, // Start status
  output logic trip_out, // Trip status
  output logic blocked_out, // Blocked status
  output logic irq // Interrupt level
);
  localparam int GW = $clog2(NUM_GROUPS);
  localparam int CW = $clog2(EVAL_CYCLES);

  nvp_meas_if meas ();

  nvp_mode_e mode_set;
  nvp_force_e force_set;
  nvp_src_e src_set;
  logic mode_allow;
  logic force_allow;
  logic [GW-1:0] group_sel;
  nvp_thr_t threshold_setting [NUM_GROUPS];
  nvp_thr_t thr_now;
  nvp_mode_e mode_eff;
  nvp_force_e force_eff;
  nvp_src_e src_use;
  nvp_eval_e state;
  logic [CW-1:0] eval_cnt;
  logic tick;
  logic eval_go;
  logic div_load;
  nvp_level_t level_in;
  nvp_level_t measured_level;
  logic blk_q;
  logic [22:0] quo;
  logic [23:0] rem;
  logic [23:0] rem_shift;
  logic [4:0] div_cnt;
  logic [15:0] ratio;
  logic [23:0] lvl_pct;
  logic [23:0] thr_rel;
  logic pickup;
  logic next_pickup;
  logic stat_start;
  logic stat_trip;
  logic stat_blocked;
  logic next_start;
  logic next_trip;
  logic next_blocked;
  logic in_test;
  logic [`NVP_INT_W-1:0] int_stat;
  logic [`NVP_INT_W-1:0] int_en;
  logic [`NVP_INT_W-1:0] int_clr;
  logic [`NVP_INT_W-1:0] events;
  logic thr_hit;

  nvp_residual u_residual (
    .mclk (mclk),
    .sys_rst (sys_rst),
    .meas (meas),
    .phase_a_voltage_re (phase_a_voltage_re),
    .phase_a_voltage_im (phase_a_voltage_im),
    .phase_b_voltage_re (phase_b_voltage_re),
    .phase_b_voltage_im (phase_b_voltage_im),
    .phase_c_voltage_re (phase_c_voltage_re),
    .phase_c_voltage_im (phase_c_voltage_im)
  );

  // Effective settings
  assign mode_eff = mode_allow ? mode_set : MODE_ON;
  assign force_eff = force_allow ? force_set : FORCE_NORMAL;
  assign in_test = (mode_eff == MODE_TEST) || (mode_eff == MODE_TEST_BLOCKED);

  always_comb begin
    case (src_set)
      SRC_AUX3: src_use = aux3_residual_mode ? SRC_AUX3 : SRC_UNSEL;
      SRC_AUX4: src_use = aux4_residual_mode ? SRC_AUX4 : SRC_UNSEL;
      default: src_use = SRC_CALC;
    endcase
  end

  // Program cycle timer
  assign tick = (eval_cnt == CW'(EVAL_CYCLES - 1));

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      eval_cnt <= '0;
    end else if (tick) begin
      eval_cnt <= '0;
    end else begin
      eval_cnt <= eval_cnt + 1'b1;
    end
  end

  // Evaluation sequence
  assign eval_go = (state == ST_IDLE) && tick && (mode_eff != MODE_OFF);
  assign meas.go = eval_go && (src_use == SRC_CALC);
  assign div_load = (eval_go && (src_use != SRC_CALC)) || ((state == ST_MEAS) && meas.done);

  always_comb begin
    if (state == ST_MEAS) begin
      level_in = meas.residual_voltage;
    end else if (src_use == SRC_AUX3) begin
      level_in = aux_channel_three;
    end else if (src_use == SRC_AUX4) begin
      level_in = aux_channel_four;
    end else begin
      level_in = '0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      blk_q <= 1'b0;
      thr_now <= `NVP_THR_RST;
      measured_level <= '0;
    end else begin
      if (div_load) begin
        measured_level <= level_in;
      end
      case (state)
        ST_IDLE: begin
          if (eval_go) begin
            // Blocking sampled once at the start of each program cycle
            blk_q <= block_in || (mode_eff == MODE_BLOCKED) || (mode_eff == MODE_TEST_BLOCKED);
            thr_now <= threshold_setting[group_sel];
            state <= (src_use == SRC_CALC) ? ST_MEAS : ST_DIV;
          end
        end
        ST_MEAS: begin
          if (meas.done) begin
            state <= ST_DIV;
          end
        end
        ST_DIV: begin
          if (div_cnt == 5'h01) begin
            state <= ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Ratio of level to threshold in 0.01 steps, restoring division
  assign rem_shift = {rem[22:0], quo[22]};

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      quo <= '0;
      rem <= '0;
      div_cnt <= '0;
    end else if (div_load) begin
      quo <= 23'(level_in) * 23'(`NVP_PCT_FULL);
      rem <= '0;
      div_cnt <= `NVP_DIV_STEPS;
    end else if ((state == ST_DIV) && (div_cnt != 5'h00)) begin
      if (rem_shift >= 24'(thr_now)) begin
        rem <= rem_shift - 24'(thr_now);
        quo <= {quo[21:0], 1'b1};
      end else begin
        rem <= rem_shift;
        quo <= {quo[21:0], 1'b0};
      end
      div_cnt <= div_cnt - 5'h01;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ratio <= '0;
    end else if (state == ST_DECIDE) begin
      ratio <= (quo[22:16] != 7'h00) ? 16'hffff : quo[15:0];
    end
  end

  // Pick-up comparator with fixed reset ratio
  assign lvl_pct = 24'(measured_level) * `NVP_PCT_FULL;
  assign thr_rel = 24'(thr_now) * `NVP_RESET_PCT;
  assign thr_hit = measured_level > 16'(thr_now);

  always_comb begin
    if (pickup) begin
      next_pickup = !(lvl_pct < thr_rel);
    end else begin
      next_pickup = thr_hit;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pickup <= 1'b0;
    end else if (mode_eff == MODE_OFF) begin
      pickup <= 1'b0;
    end else if (state == ST_DECIDE) begin
      pickup <= next_pickup;
    end
  end

  // Stage status, forcing overrides measurement
  always_comb begin
    if (mode_eff == MODE_OFF) begin
      next_start = 1'b0;
      next_trip = 1'b0;
      next_blocked = 1'b0;
    end else if (force_eff != FORCE_NORMAL) begin
      next_start = (force_eff == FORCE_START) || (force_eff == FORCE_TRIP);
      next_trip = force_eff == FORCE_TRIP;
      next_blocked = force_eff == FORCE_BLOCKED;
    end else begin
      next_start = pickup && !blk_q;
      next_trip = 1'b0;
      next_blocked = pickup && blk_q;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_start <= 1'b0;
      stat_trip <= 1'b0;
      stat_blocked <= 1'b0;
      start_out <= 1'b0;
      trip_out <= 1'b0;
      blocked_out <= 1'b0;
    end else begin
      stat_start <= next_start;
      stat_trip <= next_trip;
      stat_blocked <= next_blocked;
      // Test modes keep the status visible but start and trip quiet on the pins; blocked still drives its pin
      start_out <= next_start && !in_test;
      trip_out <= next_trip && !in_test;
      blocked_out <= next_blocked;
    end
  end

  // Event interrupt, a new event wins over a clear in the same cycle
  assign events[`NVP_INT_START_ON] = next_start && !stat_start;
  assign events[`NVP_INT_START_OFF] = !next_start && stat_start;
  assign events[`NVP_INT_TRIP_ON] = next_trip && !stat_trip;
  assign events[`NVP_INT_BLOCK_ON] = next_blocked && !stat_blocked;
  assign events[`NVP_INT_PICKUP_ON] = (state == ST_DECIDE) && next_pickup && !pickup;
  assign int_clr = (wr_en && (addr == `NVP_ADDR_INT_CLR)) ? wdata[`NVP_INT_W-1:0] : '0;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      int_stat <= '0;
      irq <= 1'b0;
    end else begin
      int_stat <= (int_stat & ~int_clr) | events;
      irq <= |(int_stat & int_en);
    end
  end

  // Static settings, untouched by setting group selection
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_set <= MODE_ON;
      force_set <= FORCE_NORMAL;
      src_set <= SRC_UNSEL;
      mode_allow <= 1'b0;
      force_allow <= 1'b0;
      group_sel <= '0;
      int_en <= '0;
    end else if (wr_en) begin
      if (addr == `NVP_ADDR_CTRL) begin
        mode_allow <= wdata[`NVP_CTRL_MODE_ALLOW];
        force_allow <= wdata[`NVP_CTRL_FORCE_ALLOW];
        force_set <= nvp_force_e'(wdata[`NVP_CTRL_FORCE]);
        if (wdata[`NVP_CTRL_MODE] <= 3'(MODE_OFF)) begin
          mode_set <= nvp_mode_e'(wdata[`NVP_CTRL_MODE]);
        end
        if (wdata[`NVP_CTRL_SRC] == 2'(SRC_AUX3)) begin
          if (aux3_residual_mode) begin
            src_set <= SRC_AUX3;
          end
        end else if (wdata[`NVP_CTRL_SRC] == 2'(SRC_AUX4)) begin
          if (aux4_residual_mode) begin
            src_set <= SRC_AUX4;
          end
        end else begin
          src_set <= nvp_src_e'(wdata[`NVP_CTRL_SRC]);
        end
      end else if (addr == `NVP_ADDR_GROUP) begin
        group_sel <= wdata[GW-1:0];
      end else if (addr == `NVP_ADDR_INT_EN) begin
        int_en <= wdata[`NVP_INT_W-1:0];
      end
    end
  end

  // Threshold bank, one per setting group, clamped to range
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_thr
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        threshold_setting[g] <= `NVP_THR_RST;
      end else if (wr_en && (addr == `NVP_ADDR_THR_BASE + 8'(4 * g))) begin
        if (wdata[31:14] != 18'h0_0000 || wdata[13:0] > `NVP_THR_MAX) begin
          threshold_setting[g] <= `NVP_THR_MAX;
        end else if (wdata[13:0] < `NVP_THR_MIN) begin
          threshold_setting[g] <= `NVP_THR_MIN;
        end else begin
          threshold_setting[g] <= wdata[13:0];
        end
      end
    end
  end

  // Read port
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (!rd_en) begin
      rdata <= '0;
    end else if (addr == `NVP_ADDR_CTRL) begin
      rdata <= '0;
      rdata[`NVP_CTRL_MODE] <= mode_set;
      rdata[`NVP_CTRL_FORCE] <= force_set;
      rdata[`NVP_CTRL_SRC] <= src_set;
      rdata[`NVP_CTRL_MODE_ALLOW] <= mode_allow;
      rdata[`NVP_CTRL_FORCE_ALLOW] <= force_allow;
    end else if (addr == `NVP_ADDR_GROUP) begin
      rdata <= 32'(group_sel);
    end else if (addr == `NVP_ADDR_STATUS) begin
      rdata <= '0;
      rdata[`NVP_ST_START] <= stat_start;
      rdata[`NVP_ST_TRIP] <= stat_trip;
      rdata[`NVP_ST_BLOCKED] <= stat_blocked;
      rdata[`NVP_ST_PICKUP] <= pickup;
      rdata[`NVP_ST_SRC] <= src_use;
      rdata[`NVP_ST_MODE] <= mode_eff;
    end else if (addr == `NVP_ADDR_LEVEL) begin
      rdata <= 32'(measured_level);
    end else if (addr == `NVP_ADDR_RATIO) begin
      rdata <= 32'(ratio);
    end else if (addr == `NVP_ADDR_INT_STAT) begin
      rdata <= 32'(int_stat);
    end else if (addr == `NVP_ADDR_INT_EN) begin
      rdata <= 32'(int_en);
    end else if (addr >= `NVP_ADDR_THR_BASE && addr < `NVP_ADDR_THR_BASE + 8'(4 * NUM_GROUPS)) begin
      rdata <= 32'(threshold_setting[addr[GW+1:2]]);
    end else begin
      rdata <= '0;
    end
  end
endmodule

`default_nettype wire

// *** src/nvp_map.svh ***
// Register map, field positions, reset values and timing counts of the
// neutral overvoltage pick-up stage. Definitions only.
`ifndef NVP_MAP_SVH
`define NVP_MAP_SVH

// Byte offsets of the register port
`define NVP_ADDR_CTRL 8'h00
`define NVP_ADDR_GROUP 8'h04
`define NVP_ADDR_STATUS 8'h08
`define NVP_ADDR_LEVEL 8'h0c
`define NVP_ADDR_RATIO 8'h10
`define NVP_ADDR_INT_STAT 8'h14
`define NVP_ADDR_INT_EN 8'h18
`define NVP_ADDR_INT_CLR 8'h1c
`define NVP_ADDR_THR_BASE 8'h20

// Control register fields
`define NVP_CTRL_MODE 2:0
`define NVP_CTRL_FORCE 5:4
`define NVP_CTRL_SRC 9:8
`define NVP_CTRL_MODE_ALLOW 12
`define NVP_CTRL_FORCE_ALLOW 13

// Status register fields
`define NVP_ST_START 0
`define NVP_ST_TRIP 1
`define NVP_ST_BLOCKED 2
`define NVP_ST_PICKUP 3
`define NVP_ST_SRC 5:4
`define NVP_ST_MODE 10:8

// Interrupt bits
`define NVP_INT_W 5
`define NVP_INT_START_ON 0
`define NVP_INT_START_OFF 1
`define NVP_INT_TRIP_ON 2
`define NVP_INT_BLOCK_ON 3
`define NVP_INT_PICKUP_ON 4

// Threshold in 0.01 % of nominal voltage
`define NVP_THR_RST 14'h07d0
`define NVP_THR_MIN 14'h0064
`define NVP_THR_MAX 14'h26ac
`define NVP_PCT_FULL 24'h00_0064
`define NVP_RESET_PCT 24'h00_0061
`define NVP_THIRD_MUL 18'h0_5556
`define NVP_NUM_GROUPS 32'h0000_0008

// Timing
`define NVP_CLK_PERIOD_NS 32'h0000_0028
`define NVP_EVAL_PERIOD_NS 32'h000f_4240
`define NVP_EVAL_CYCLES (`NVP_EVAL_PERIOD_NS / `NVP_CLK_PERIOD_NS)
`define NVP_BLOCK_LEAD_MS 32'h0000_0005
`define NVP_DIV_STEPS 5'h17
`define NVP_SQRT_TOP 5'h11

`endif

// *** src/nvp_pkg.sv ***
// Types of the neutral overvoltage pick-up stage.
// Assumes a SystemVerilog compiler and nothing else.
`default_nettype none

package nvp_pkg;
  typedef enum logic [2:0] {
    MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF
  } nvp_mode_e;
  typedef enum logic [1:0] {
    FORCE_NORMAL, FORCE_START, FORCE_TRIP, FORCE_BLOCKED
  } nvp_force_e;
  typedef enum logic [1:0] {SRC_UNSEL, SRC_CALC, SRC_AUX3, SRC_AUX4} nvp_src_e;
  typedef enum logic [1:0] {ST_IDLE, ST_MEAS, ST_DIV, ST_DECIDE} nvp_eval_e;
  typedef logic [15:0] nvp_level_t;
  typedef logic [13:0] nvp_thr_t;
endpackage

`default_nettype wire

// *** src/nvp_meas_if.sv ***
// Request and result between the stage and its residual calculator.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none

interface nvp_meas_if;
  logic go;
  logic done;
  nvp_pkg::nvp_level_t residual_voltage;
  modport owner (output go, input done, residual_voltage);
  modport calc (input go, output done, residual_voltage);
endinterface

`default_nettype wire

// *** src/nvp_residual.sv ***
// Calculated residual level from the three phase fundamental phasors.
// Assumes phasors in 0.01 % of phase nominal; result in 0.01 % of nominal.
`timescale 1ns/1ns
`default_nettype none
`include "nvp_map.svh"

module nvp_residual import nvp_pkg::*; (
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Async reset
  nvp_meas_if.calc meas, // Request and result
  input wire logic signed [15:0] phase_a_voltage_re, // Phase A real part
  input wire logic signed [15:0] phase_a_voltage_im, // Phase A imaginary part
  input wire logic signed [15:0] phase_b_voltage_re, // Phase B real part
  input wire logic signed [15:0] phase_b_voltage_im, // Phase B imaginary part
  input wire logic signed [15:0] phase_c_voltage_re, // Phase C real part
  input wire logic signed [15:0] phase_c_voltage_im // Phase C imaginary part
);
  logic signed [17:0] sum_re;
  logic signed [17:0] sum_im;
  logic [35:0] mag_sq;
  logic [17:0] root;
  logic [17:0] trial;
  logic [35:0] trial_sq;
  logic [35:0] third;
  logic [4:0] bit_idx;
  logic busy;
  logic fin;

  // Vector sum of fundamental phasors, then square root and one third
  // Widen before squaring so the product keeps all its bits
  assign mag_sq = 36'(sum_re) * 36'(sum_re) + 36'(sum_im) * 36'(sum_im);
  assign trial = root | (18'h0_0001 << bit_idx);
  assign trial_sq = 36'(trial) * 36'(trial);
  assign third = 36'(root) * 36'(`NVP_THIRD_MUL);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sum_re <= '0;
      sum_im <= '0;
      root <= '0;
      bit_idx <= '0;
      busy <= 1'b0;
      fin <= 1'b0;
    end else if (meas.go && !busy) begin
      sum_re <= 18'(phase_a_voltage_re) + 18'(phase_b_voltage_re) + 18'(phase_c_voltage_re);
      sum_im <= 18'(phase_a_voltage_im) + 18'(phase_b_voltage_im) + 18'(phase_c_voltage_im);
      root <= '0;
      bit_idx <= `NVP_SQRT_TOP;
      busy <= 1'b1;
      fin <= 1'b0;
    end else if (busy) begin
      if (trial_sq <= mag_sq) begin
        root <= trial;
      end
      if (bit_idx == 5'h00) begin
        busy <= 1'b0;
        fin <= 1'b1;
      end else begin
        bit_idx <= bit_idx - 5'h01;
      end
    end else begin
      fin <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meas.residual_voltage <= '0;
      meas.done <= 1'b0;
    end else begin
      meas.done <= fin;
      if (fin) begin
        meas.residual_voltage <= third[31:16];
      end
    end
  end
endmodule

`default_nettype wire

// *** sim/nvp_stage_assertions.sv ***
// Port checks of the neutral overvoltage pick-up stage.
// Assumes a bind onto nvp_stage and a one-cycle strobe master.
`timescale 1ns/1ns
`default_nettype none

module nvp_stage_assertions (
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [7:0] addr, // Address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr_en, // Write
  input wire logic rd_en, // Read
  input wire logic [31:0] rdata, // Read data
  input wire logic start_out, // Start
  input wire logic trip_out, // Trip
  input wire logic blocked_out, // Blocked
  input wire logic irq // Interrupt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence wr_ctrl;
    wr_en && addr == 8'h00 && wdata[2:0] <= 3'h4 && wdata[9:8] <= 2'h1;
  endsequence
  sequence wr_thr;
    wr_en && addr == 8'h24 && wdata >= 32'h0000_0064 && wdata <= 32'h0000_26ac;
  endsequence
  a_reset_quiet: assert property (
    $past(sys_rst) |-> !start_out && !trip_out && !blocked_out && !irq && rdata == 32'h0)
    else $error("outputs busy after reset");
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  a_trip_start: assert property (trip_out |-> start_out)
    else $error("trip without start");
  a_ctrl_back: assert property (
    wr_ctrl ##1 (rd_en && addr == 8'h00)
    |=> (rdata & 32'h0000_3337) == ($past(wdata, 2) & 32'h0000_3337))
    else $error("control readback differs");
  a_thr_back: assert property (
    wr_thr ##1 (rd_en && addr == 8'h24) |=> rdata == $past(wdata, 2))
    else $error("threshold readback differs");
  a_off_quiet: assert property (
    wr_en && addr == 8'h00 && wdata[12] && wdata[2:0] == 3'h4
    |-> ##3 !start_out && !trip_out && !blocked_out)
    else $error("output active in off mode");
  a_test_mute: assert property (
    wr_en && addr == 8'h00 && wdata[12] && wdata[2:1] == 2'b01
    |-> ##3 !start_out && !trip_out)
    else $error("start or trip in test mode");
  a_force_trip: assert property (
    wr_en && addr == 8'h00 && wdata[13] && !wdata[12] && wdata[5:4] == 2'h2
    |-> ##3 start_out && trip_out)
    else $error("forced trip missing");
  a_irq_mask: assert property (wr_en && addr == 8'h18 && wdata[4:0] == 5'h0 |-> ##2 !irq)
    else $error("interrupt while masked");
endmodule

`default_nettype wire

// *** sim/nvp_front_end.sv ***
// Model of the measurement front end and blocking matrix.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ns
`default_nettype none

module nvp_front_end (
  input wire logic mclk, // Clock
  output logic signed [15:0] ar, // Phase A re
  output logic signed [15:0] ai, // Phase A im
  output logic signed [15:0] br, // Phase B re
  output logic signed [15:0] bi, // Phase B im
  output logic signed [15:0] cr, // Phase C re
  output logic signed [15:0] ci, // Phase C im
  output wire logic [15:0] x3, // Aux three
  output wire logic [15:0] x4, // Aux four
  output logic m3, // Aux three residual
  output logic m4, // Aux four residual
  output logic blk // Blocking
);
  logic [15:0] l3 = 16'h0000;
  logic [15:0] junk = 16'h0000;
  // Channel outside residual mode carries unrelated data
  assign x3 = m3 ? l3 : junk;
  assign x4 = m4 ? l3 : ~junk;
  always @(posedge mclk) junk <= junk + 16'h1357;
  initial {ar, ai, br, bi, cr, ci, m3, m4, blk} <= '0;
  // Fundamental phasor parts only
  task automatic set_ph(input logic [15:0] a, b, c, d, e, f);
    @(posedge mclk);
    {ar, ai, br, bi, cr, ci} <= {a, b, c, d, e, f};
  endtask
  task automatic set_aux(input logic [15:0] a, input logic e3, e4);
    @(posedge mclk);
    {l3, m3, m4} <= {a, e3, e4};
  endtask
  // Held across whole program cycles, far ahead of any delay
  task automatic set_blk(input logic b);
    @(posedge mclk);
    blk <= b;
  endtask
endmodule

`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench of the neutral overvoltage pick-up stage.
// Assumes design, front-end model and checker compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic mclk, sys_rst, wr_en, rd_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  int bad_count, compares;
  wire logic [31:0] rdata;
  wire logic signed [15:0] ar, ai, br, bi, cr, ci;
  wire logic [15:0] x3, x4;
  wire logic m3, m4, blk, st, tr, bl, irq;
  // Control word, then expected start, trip, blocked
  localparam logic [34:0] MODES [5] = '{{32'h0000_0204, 3'b100}, {32'h0000_1201, 3'b001},
    {32'h0000_1202, 3'b000}, {32'h0000_1203, 3'b001}, {32'h0000_1204, 3'b000}};
  localparam logic [34:0] FORCES [5] = '{{32'h0000_0220, 3'b000}, {32'h0000_2210, 3'b100},
    {32'h0000_2220, 3'b110}, {32'h0000_2230, 3'b001}, {32'h0000_3224, 3'b000}};

  nvp_stage #(.EVAL_CYCLES(100)) uut (.mclk(mclk), .sys_rst(sys_rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .phase_a_voltage_re(ar), .phase_a_voltage_im(ai), .phase_b_voltage_re(br),
    .phase_b_voltage_im(bi), .phase_c_voltage_re(cr), .phase_c_voltage_im(ci),
    .aux_channel_three(x3), .aux_channel_four(x4), .aux3_residual_mode(m3),
    .aux4_residual_mode(m4), .block_in(blk), .start_out(st), .trip_out(tr),
    .blocked_out(bl), .irq(irq));
  nvp_front_end fe (.mclk(mclk), .ar(ar), .ai(ai), .br(br), .bi(bi), .cr(cr),
    .ci(ci), .x3(x3), .x4(x4), .m3(m3), .m4(m4), .blk(blk));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // A write is followed at once by a read of the same place
  task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    if (w) begin
      @(posedge mclk);
      wr_en <= 1'b0;
      rd_en <= 1'b1;
    end
    @(posedge mclk);
    rd_en <= 1'b0;
  endtask
  task automatic rw(input string n, input logic [7:0] a, input logic [31:0] d, e,
    input logic w);
    acc(a, d, w);
    #1 chk(n, rdata, e);
  endtask
  // 250 clocks: two and a half program cycles, well over one cycle plus evaluation latency
  task automatic ev(input logic [2:0] e);
    repeat (250) @(posedge mclk);
    #1 chk("outputs", {29'h0, st, tr, bl}, {29'h0, e});
  endtask
  task automatic lv(input logic [15:0] l);
    fe.set_aux(l, 1'b1, 1'b0);
  endtask

  task automatic t_defaults;
    rw("ctrl", 8'h00, 0, 32'h0000_0000, 0);
    rw("thr0", 8'h20, 0, 32'h0000_07d0, 0);
    rw("thr7", 8'h3c, 0, 32'h0000_07d0, 0);
    rw("unmapped", 8'h40, 0, 32'h0000_0000, 0);
    $display("defaults done");
  endtask
  task automatic t_pickup;
    lv(16'h07d0);
    rw("ctrl", 8'h00, 32'h0000_0200, 32'h0000_0200, 1);
    ev(3'b000);
    rw("level", 8'h0c, 0, 32'h0000_07d0, 0);
    lv(16'h07d1);
    ev(3'b100);
    rw("ratio", 8'h10, 0, 32'h0000_0064, 0);
    rw("status", 8'h08, 0, 32'h0000_0029, 0);
    lv(16'h0794);
    ev(3'b100);
    lv(16'h0793);
    ev(3'b000);
    lv(16'h07c6);
    ev(3'b000);
    $display("pickup done");
  endtask
  task automatic t_block;
    rw("ctrl", 8'h00, 32'h0000_0300, 32'h0000_0200, 1);
    lv(16'h07d1);
    ev(3'b100);
    fe.set_blk(1'b1);
    ev(3'b001);
    fe.set_blk(1'b0);
    ev(3'b100);
    $display("block done");
  endtask
  task automatic t_group;
    rw("thr1", 8'h24, 32'h0000_0bb8, 32'h0000_0bb8, 1);
    rw("thr2 low", 8'h28, 32'h0000_0032, 32'h0000_0064, 1);
    rw("thr2 high", 8'h28, 32'h0000_ffff, 32'h0000_26ac, 1);
    acc(8'h04, 32'h0000_0001, 1);
    ev(3'b000);
    rw("ctrl", 8'h00, 0, 32'h0000_0200, 0);
    acc(8'h04, 32'h0000_0000, 1);
    ev(3'b100);
    $display("group done");
  endtask
  task automatic t_table(input logic [15:0] l, input logic [34:0] tab [5]);
    lv(l);
    foreach (tab[i]) begin
      acc(8'h00, tab[i][34:3], 1);
      ev(tab[i][2:0]);
    end
    $display("table done");
  endtask
  task automatic t_calc;
    rw("ctrl", 8'h00, 32'h0000_1005, 32'h0000_1004, 1);
    fe.set_ph(16'h2710, 16'h0000, 16'h2710, 16'h0000, 16'h2710, 16'h0000);
    rw("ctrl", 8'h00, 32'h0000_0100, 32'h0000_0100, 1);
    ev(3'b100);
    acc(8'h0c, 0, 0);
    #1 chk("level", 32'(rdata >= 32'h0000_270e && rdata <= 32'h0000_2712), 1);
    fe.set_ph(16'h2710, 16'h0000, 16'hec78, 16'h21d4, 16'hec78, 16'hde2c);
    ev(3'b000);
    $display("calc done");
  endtask
  task automatic t_irq;
    acc(8'h1c, 32'h0000_001f, 1);
    rw("int_en", 8'h18, 32'h0000_001f, 32'h0000_001f, 1);
    lv(16'h07d1);
    acc(8'h00, 32'h0000_0200, 1);
    ev(3'b100);
    chk("irq", 32'(irq), 1);
    rw("int_stat", 8'h14, 0, 32'h0000_0011, 0);
    acc(8'h18, 32'h0000_0000, 1);
    #1 chk("irq masked", 32'(irq), 0);
    acc(8'h18, 32'h0000_001f, 1);
    #1 chk("irq", 32'(irq), 1);
    acc(8'h1c, 32'h0000_001f, 1);
    #1 chk("irq cleared", 32'(irq), 0);
    rw("int_stat", 8'h14, 0, 32'h0000_0000, 0);
    $display("irq done");
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    close_out();
  end

  initial begin
    sys_rst <= 1'b1;
    {wr_en, rd_en, addr, wdata} <= '0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    t_defaults();
    t_pickup();
    t_block();
    t_group();
    t_table(16'h07d1, MODES);
    t_table(16'h0064, FORCES);
    t_calc();
    t_irq();
    close_out();
  end
endmodule

bind nvp_stage nvp_stage_assertions sva (.mclk(mclk), .sys_rst(sys_rst), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .start_out(start_out),
  .trip_out(trip_out), .blocked_out(blocked_out), .irq(irq));

`default_nettype wire
